// *** hdl/pstel_pkg.sv ***
package pstel_pkg;
  // Clock and link timing
  localparam int CLK_HZ = 25_000_000;
  localparam int SYNC_HZ = 500_000;
  localparam int SYNC_DIV = CLK_HZ / SYNC_HZ;
  localparam int SYNC_HALF = SYNC_DIV / 2;
  localparam int LINK_BUSY = 4;
  localparam int REFRESH_MS = 1000;
  localparam int REFRESH_CYCLES = CLK_HZ / 1000 * REFRESH_MS;
  localparam int MIN_TIMEOUT_MS = 150;
  // Widths
  localparam int ADC_W = 12;
  localparam int TEL_W = 8;
  localparam int COEF_W = 8;
  localparam int DROOP_W = 4;
  localparam int CNT_W = 6;
  localparam int SID_AW = 4;
  localparam int TRIM_W = 6;
  localparam int AV_AW = 6;
  // Arithmetic scaling
  localparam logic [TEL_W-1:0] T_REF = 8'h40;
  localparam int DROOP_SHIFT = 4;
  localparam int OUT_SHIFT = 6;
  localparam int ROLL_SHIFT = 8;
  localparam int NOISE_AMP = 16;
  localparam int DUTY_MAX = (1 << ADC_W) - 1;
  localparam int FOLLOW_STEPS = 2;
  localparam logic [6:0] LFSR_SEED = 7'h01;
  // Register offsets (byte addresses)
  localparam logic [AV_AW-1:0] OFF_CTRL = 6'h00;
  localparam logic [AV_AW-1:0] OFF_PROP = 6'h04;
  localparam logic [AV_AW-1:0] OFF_INTEG = 6'h08;
  localparam logic [AV_AW-1:0] OFF_DERIV = 6'h0c;
  localparam logic [AV_AW-1:0] OFF_ROLL = 6'h10;
  localparam logic [AV_AW-1:0] OFF_STAT = 6'h14;
  localparam logic [AV_AW-1:0] OFF_TELV = 6'h18;
  localparam logic [AV_AW-1:0] OFF_TELIT = 6'h1c;
  localparam logic [AV_AW-1:0] OFF_SIDIDX = 6'h20;
  localparam logic [AV_AW-1:0] OFF_SIDDAT = 6'h24;
  localparam logic [AV_AW-1:0] OFF_TMO = 6'h28;
  // Control field positions and reset values
  localparam int CTRL_SID_BIT = 0;
  localparam int CTRL_FOLLOW_BIT = 1;
  localparam int CTRL_DROOP_LSB = 4;
  localparam logic [COEF_W-1:0] COEF_RST = 8'h00;
  // Identification sequencer
  typedef enum logic [1:0] {
    SID_IDLE = 2'b00,
    SID_RUN = 2'b01,
    SID_DONE = 2'b11
  } pstel_sid_e;
endpackage : pstel_pkg

// *** hdl/pstel_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface pstel_link_if;
  import pstel_pkg::*;
  // Sync line and configuration pushed on it
  logic syncLine;
  logic [COEF_W-1:0] propCoeff;
  logic [COEF_W-1:0] integCoeff;
  logic [COEF_W-1:0] derivCoeff;
  logic [COEF_W-1:0] rolloffCoeff;
  logic [DROOP_W-1:0] droopSetting;
  // Identification control and capture readback
  logic sysidEn;
  logic sysidDone;
  logic [SID_AW-1:0] sysidIdx;
  logic [ADC_W-1:0] sysidData;
  // Telemetry
  logic [ADC_W-1:0] voltReading;
  logic [TEL_W-1:0] curReading;
  logic [TEL_W-1:0] tempReading;
  // Open-drain share line; csExt is the level the other converters leave
  logic csOut;
  logic csOe;
  logic csExt;
  logic csLevel;
  assign csLevel = csExt & ~(csOe & ~csOut);
  modport conv (
    input syncLine, propCoeff, integCoeff, derivCoeff, rolloffCoeff, droopSetting,
    input sysidEn, sysidIdx, csLevel,
    output sysidDone, sysidData, voltReading, curReading, tempReading, csOut, csOe
  );
  modport mgr (
    output syncLine, propCoeff, integCoeff, derivCoeff, rolloffCoeff, droopSetting,
    output sysidEn, sysidIdx,
    input sysidDone, sysidData, voltReading, curReading, tempReading
  );
endinterface : pstel_link_if
`default_nettype wire

// *** hdl/pstel_share_meter.sv ***
`timescale 1ns/10ps
`default_nettype none
module pstel_share_meter #(
  parameter int CNT_W = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Share line and period marker
  input wire logic lineLevel,
  input wire logic periodTick,
  // Low cycles seen in the last whole period
  output logic [CNT_W-1:0] lowCount
);
  logic lineMeta_q;
  logic lineSafe_q;
  logic [CNT_W-1:0] lowAcc_q;
  logic [CNT_W-1:0] lowCount_q;
  wire logic accFull = &lowAcc_q;

  // Line is asynchronous to us; only the second flop feeds the counter
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      lineMeta_q <= 1'b1;
      lineSafe_q <= 1'b1;
      lowAcc_q <= '0;
      lowCount_q <= '0;
    end
    else
    begin
      lineMeta_q <= lineLevel;
      lineSafe_q <= lineMeta_q;
      if (periodTick)
      begin
        lowCount_q <= lowAcc_q;
        lowAcc_q <= '0;
      end
      else if (!lineSafe_q && !accFull)
        lowAcc_q <= lowAcc_q + 1'b1;
    end
  end
  assign lowCount = lowCount_q;
endmodule : pstel_share_meter
`default_nettype wire

// *** hdl/pstel_converter.sv ***
`timescale 1ns/10ps
`default_nettype none
module pstel_converter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Link to the power manager
  pstel_link_if.conv link,
  // Analog front end samples and setpoint
  input wire logic [pstel_pkg::ADC_W-1:0] refVoltage,
  input wire logic [pstel_pkg::ADC_W-1:0] adcVoltage,
  input wire logic [pstel_pkg::ADC_W-1:0] adcCurrent,
  input wire logic [pstel_pkg::ADC_W-1:0] adcTemp,
  // Modulator command
  output logic [pstel_pkg::ADC_W-1:0] pwmDuty,
  output logic pwmStart
);
  import pstel_pkg::*;

  logic syncMeta_q;
  logic syncSafe_q;
  logic syncPrev_q;
  logic [CNT_W-1:0] shareCnt_q;
  logic [ADC_W-1:0] volt_q;
  logic [TEL_W-1:0] curCorr_q;
  logic [TEL_W-1:0] temp_q;
  logic [TRIM_W-1:0] trim_q;
  logic csOe_q;
  logic signed [13:0] errPrev_q;
  logic signed [23:0] integ_q;
  logic signed [23:0] dFilt_q;
  logic [ADC_W-1:0] duty_q;
  logic start_q;
  logic [6:0] lfsr_q;
  logic [SID_AW-1:0] sidIdx_q;
  logic [ADC_W-1:0] sidMem [1 << SID_AW];
  logic [ADC_W-1:0] sidData_q;
  logic sidDone_q;
  logic [CNT_W-1:0] lowCount;
  pstel_sid_e sidState_q;
  pstel_sid_e sidState_d;

  // Sync line comes from another chip: two flops, third only for the edge
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      syncMeta_q <= 1'b1;
      syncSafe_q <= 1'b1;
      syncPrev_q <= 1'b1;
    end
    else
    begin
      syncMeta_q <= link.syncLine;
      syncSafe_q <= syncMeta_q;
      syncPrev_q <= syncSafe_q;
    end
  end
  wire logic tick = syncPrev_q & ~syncSafe_q;

  // Share period counter restarts on each sync falling edge
  wire logic cntTop = shareCnt_q == CNT_W'(SYNC_DIV - 1);
  wire logic [CNT_W-1:0] shareCnt_d = tick ? '0 : cntTop ? shareCnt_q : shareCnt_q + 1'b1;

  // Temperature correction of the inductor-sensed current
  wire logic [TEL_W-1:0] curRaw = adcCurrent[ADC_W-1 -: TEL_W];
  wire logic [TEL_W-1:0] tempRaw = adcTemp[ADC_W-1 -: TEL_W];
  wire logic signed [11:0] tempDelta = $signed({4'h0, tempRaw}) - $signed({4'h0, T_REF});
  wire logic signed [23:0] corrProd = $signed({4'h0, curRaw}) * tempDelta;
  wire logic signed [11:0] curAdj = $signed({4'h0, curRaw}) - $signed(corrProd[19:8]);
  wire logic [TEL_W-1:0] curCorr_d = curAdj[11] ? '0 : (|curAdj[10:8]) ? 8'hff : curAdj[7:0];

  // Droop: voltage drop grows with load and the share pulse is shortened
  wire logic [DROOP_W-1:0] droopSet = link.droopSetting;
  wire logic [11:0] droopProd = curCorr_q * droopSet;
  wire logic [11:0] droopDrop = droopProd >> DROOP_SHIFT;
  wire logic [13:0] ownProd = curCorr_q * CNT_W'(SYNC_DIV);
  wire logic [CNT_W-1:0] ownBase = ownProd[13:8];
  wire logic [CNT_W-1:0] droopCnt = CNT_W'(droopSet);
  wire logic [CNT_W-1:0] ownLow = (ownBase > droopCnt) ? ownBase - droopCnt : '0;

  // Share tracking trim; clamps instead of wrapping so a stuck line cannot run away
  wire logic trimUp = (lowCount > ownLow) && !(&trim_q);
  wire logic trimDn = (lowCount < ownLow) && (|trim_q);

  // PID arithmetic on the effective setpoint
  wire logic signed [13:0] refSum = $signed({2'b00, refVoltage}) + $signed({8'h00, trim_q})
                                    - $signed({2'b00, droopDrop});
  wire logic signed [13:0] err = refSum - $signed({2'b00, adcVoltage});
  wire logic signed [22:0] pTerm = err * $signed({1'b0, link.propCoeff});
  wire logic signed [22:0] iStep = err * $signed({1'b0, link.integCoeff});
  wire logic signed [24:0] integSum = integ_q + iStep;
  wire logic integOvf = integSum[24] ^ integSum[23];
  wire logic signed [23:0] integ_d = integOvf ? {integSum[24], {23{~integSum[24]}}}
                                             : integSum[23:0];
  wire logic signed [14:0] dDiff = err - errPrev_q;
  wire logic signed [23:0] dRaw = dDiff * $signed({1'b0, link.derivCoeff});
  wire logic signed [24:0] dGap = dRaw - dFilt_q;
  wire logic signed [33:0] dStep = dGap * $signed({1'b0, link.rolloffCoeff});
  wire logic signed [23:0] dFilt_d = dFilt_q + 24'(dStep >>> ROLL_SHIFT);
  wire logic signed [25:0] total = pTerm + integ_q + dFilt_q;
  wire logic sidRun = sidState_q == SID_RUN;
  wire logic signed [25:0] noise = !sidRun ? 26'sh0 : lfsr_q[0] ? 26'(NOISE_AMP)
                                   : -26'(NOISE_AMP);
  wire logic signed [25:0] dutyS = (total >>> OUT_SHIFT) + noise;
  wire logic [ADC_W-1:0] duty_d = dutyS[25] ? '0 : (dutyS > 26'(DUTY_MAX)) ?
                                  ADC_W'(DUTY_MAX) : dutyS[ADC_W-1:0];

  // Per-cycle loop state: updates happen on the sync edge only, except share counter, csOe and start, which update every cycle
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      shareCnt_q <= '0;
      csOe_q <= 1'b0;
      volt_q <= '0;
      curCorr_q <= '0;
      temp_q <= '0;
      trim_q <= '0;
      errPrev_q <= '0;
      integ_q <= '0;
      dFilt_q <= '0;
      duty_q <= '0;
      start_q <= 1'b0;
    end
    else
    begin
      shareCnt_q <= shareCnt_d;
      csOe_q <= shareCnt_d < ownLow;
      start_q <= tick;
      if (tick)
      begin
        volt_q <= adcVoltage;
        curCorr_q <= curCorr_d;
        temp_q <= tempRaw;
        trim_q <= trimUp ? trim_q + 1'b1 : trimDn ? trim_q - 1'b1 : trim_q;
        errPrev_q <= err;
        integ_q <= integ_d;
        dFilt_q <= dFilt_d;
        duty_q <= duty_d;
      end
    end
  end

  // Identification sequencer
  always_comb
  begin
    sidState_d = sidState_q;
    case (sidState_q)
      SID_IDLE:
        if (link.sysidEn)
          sidState_d = SID_RUN;
      SID_RUN:
        if (!link.sysidEn)
          sidState_d = SID_IDLE;
        else if (tick && (&sidIdx_q))
          sidState_d = SID_DONE;
      SID_DONE:
        if (!link.sysidEn)
          sidState_d = SID_IDLE;
      default:
        sidState_d = SID_IDLE;
    endcase
  end

  // PRBS generator and capture index
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sidState_q <= SID_IDLE;
      lfsr_q <= LFSR_SEED;
      sidIdx_q <= '0;
      sidDone_q <= 1'b0;
      sidData_q <= '0;
    end
    else
    begin
      sidState_q <= sidState_d;
      sidDone_q <= sidState_d == SID_DONE;
      sidData_q <= sidMem[link.sysidIdx];
      if (!sidRun)
        sidIdx_q <= '0;
      else if (tick)
      begin
        lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
        sidIdx_q <= sidIdx_q + 1'b1;
      end
    end
  end

  // Response capture memory; contents are meaningless until a run ends
  always_ff @(posedge core_clk)
  begin
    if (sidRun && tick)
      sidMem[sidIdx_q] <= adcVoltage;
  end

  pstel_share_meter #(
    .CNT_W(CNT_W)
  ) u_meter (
    .core_clk(core_clk),
    .reset(reset),
    .lineLevel(link.csLevel),
    .periodTick(tick),
    .lowCount(lowCount)
  );

  // Link and user outputs straight from flops; csOut is tied low
  assign link.csOut = 1'b0;
  assign link.csOe = csOe_q;
  assign link.voltReading = volt_q;
  assign link.curReading = curCorr_q;
  assign link.tempReading = temp_q;
  assign link.sysidDone = sidDone_q;
  assign link.sysidData = sidData_q;
  assign pwmDuty = duty_q;
  assign pwmStart = start_q;
endmodule : pstel_converter
`default_nettype wire

// *** hdl/pstel_manager.sv ***
`timescale 1ns/10ps
`default_nettype none
module pstel_manager #(
  parameter int REFRESH_CYC = pstel_pkg::REFRESH_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [pstel_pkg::AV_AW-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Link to the converter
  pstel_link_if.mgr link
);
  import pstel_pkg::*;
  localparam int RW = $clog2(REFRESH_CYC);

  logic [CNT_W-1:0] divCnt_q;
  logic syncLine_q;
  logic [RW-1:0] refCnt_q;
  logic waitReq_q;
  logic [31:0] rdData_q;
  logic [COEF_W-1:0] prop_q;
  logic [COEF_W-1:0] integ_q;
  logic [COEF_W-1:0] deriv_q;
  logic [COEF_W-1:0] roll_q;
  logic [3:0] loaded_q;
  logic follower_q;
  logic [DROOP_W-1:0] droop_q;
  logic sysidEn_q;
  logic [SID_AW-1:0] sidIdx_q;
  logic sidDoneSeen_q;
  logic [COEF_W-1:0] propL_q;
  logic [COEF_W-1:0] integL_q;
  logic [COEF_W-1:0] derivL_q;
  logic [COEF_W-1:0] rollL_q;
  logic [DROOP_W-1:0] droopL_q;
  logic [ADC_W-1:0] telV_q;
  logic [TEL_W-1:0] telI_q;
  logic [TEL_W-1:0] telT_q;

  // Sync generator and the push window that follows each falling edge
  wire logic [CNT_W-1:0] divCnt_d = (divCnt_q == CNT_W'(SYNC_DIV - 1)) ? '0 : divCnt_q + 1'b1;
  wire logic pushEdge = divCnt_q == CNT_W'(SYNC_HALF - 1);
  wire logic busyWin = (divCnt_q >= CNT_W'(SYNC_HALF)) &&
                       (divCnt_q < CNT_W'(SYNC_HALF + LINK_BUSY));
  wire logic refresh = refCnt_q == RW'(REFRESH_CYC - 1);

  // Bus handshake: one low cycle of waitrequest per request
  wire logic req = read | write;
  wire logic grant = req && waitReq_q && !busyWin;
  wire logic wrEn = write && !waitReq_q;
  wire logic wrCtrl = wrEn && (address == OFF_CTRL);
  wire logic sidReq = wrCtrl && writedata[CTRL_SID_BIT] && (&loaded_q);
  wire logic [DROOP_W:0] droopSum = {1'b0, droop_q} +
                                    (follower_q ? (DROOP_W + 1)'(FOLLOW_STEPS) : '0);
  wire logic [DROOP_W-1:0] droopOut = droopSum[DROOP_W] ? '1 : droopSum[DROOP_W-1:0];

  // Read selection; unmapped offsets read as zero
  wire logic [31:0] rdMux =
    (address == OFF_CTRL) ? {24'h0, droop_q, 2'b00, follower_q, sysidEn_q} :
    (address == OFF_PROP) ? {24'h0, prop_q} :
    (address == OFF_INTEG) ? {24'h0, integ_q} :
    (address == OFF_DERIV) ? {24'h0, deriv_q} :
    (address == OFF_ROLL) ? {24'h0, roll_q} :
    (address == OFF_STAT) ? {26'h0, sidDoneSeen_q, sysidEn_q, loaded_q} :
    (address == OFF_TELV) ? {20'h0, telV_q} :
    (address == OFF_TELIT) ? {16'h0, telT_q, telI_q} :
    (address == OFF_SIDIDX) ? {28'h0, sidIdx_q} :
    (address == OFF_SIDDAT) ? {20'h0, link.sysidData} :
    (address == OFF_TMO) ? 32'(MIN_TIMEOUT_MS) : 32'h0;

  // Timing: divider, refresh, bus handshake
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      divCnt_q <= '0;
      syncLine_q <= 1'b1;
      refCnt_q <= '0;
      waitReq_q <= 1'b1;
      rdData_q <= '0;
    end
    else
    begin
      divCnt_q <= divCnt_d;
      syncLine_q <= divCnt_d < CNT_W'(SYNC_HALF);
      refCnt_q <= refresh ? '0 : refCnt_q + 1'b1;
      waitReq_q <= !grant;
      if (grant)
        rdData_q <= rdMux;
    end
  end

  // Software registers; hardware clear of the run flag loses to a new start
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      prop_q <= COEF_RST;
      integ_q <= COEF_RST;
      deriv_q <= COEF_RST;
      roll_q <= COEF_RST;
      loaded_q <= '0;
      follower_q <= 1'b0;
      droop_q <= '0;
      sysidEn_q <= 1'b0;
      sidIdx_q <= '0;
      sidDoneSeen_q <= 1'b0;
    end
    else
    begin
      if (wrEn && (address == OFF_PROP))
      begin
        prop_q <= writedata[COEF_W-1:0];
        loaded_q[0] <= 1'b1;
      end
      if (wrEn && (address == OFF_INTEG))
      begin
        integ_q <= writedata[COEF_W-1:0];
        loaded_q[1] <= 1'b1;
      end
      if (wrEn && (address == OFF_DERIV))
      begin
        deriv_q <= writedata[COEF_W-1:0];
        loaded_q[2] <= 1'b1;
      end
      if (wrEn && (address == OFF_ROLL))
      begin
        roll_q <= writedata[COEF_W-1:0];
        loaded_q[3] <= 1'b1;
      end
      if (wrEn && (address == OFF_SIDIDX))
        sidIdx_q <= writedata[SID_AW-1:0];
      if (wrCtrl)
      begin
        follower_q <= writedata[CTRL_FOLLOW_BIT];
        droop_q <= writedata[CTRL_DROOP_LSB +: DROOP_W];
      end
      if (sidReq)
        sysidEn_q <= 1'b1;
      else if (link.sysidDone || wrCtrl)
        sysidEn_q <= 1'b0;
      // Link done lasts two cycles, too short to poll; a finishing run beats a restart
      if (link.sysidDone)
        sidDoneSeen_q <= 1'b1;
      else if (sidReq)
        sidDoneSeen_q <= 1'b0;
    end
  end

  // Link copies change only with the sync falling edge; telemetry once per second
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      propL_q <= COEF_RST;
      integL_q <= COEF_RST;
      derivL_q <= COEF_RST;
      rollL_q <= COEF_RST;
      droopL_q <= '0;
      telV_q <= '0;
      telI_q <= '0;
      telT_q <= '0;
    end
    else
    begin
      if (pushEdge)
      begin
        propL_q <= prop_q;
        integL_q <= integ_q;
        derivL_q <= deriv_q;
        rollL_q <= roll_q;
        droopL_q <= droopOut;
      end
      if (refresh)
      begin
        telV_q <= link.voltReading;
        telI_q <= link.curReading;
        telT_q <= link.tempReading;
      end
    end
  end

  assign readdata = rdData_q;
  assign waitrequest = waitReq_q;
  assign link.syncLine = syncLine_q;
  assign link.propCoeff = propL_q;
  assign link.integCoeff = integL_q;
  assign link.derivCoeff = derivL_q;
  assign link.rolloffCoeff = rollL_q;
  assign link.droopSetting = droopL_q;
  assign link.sysidEn = sysidEn_q;
  assign link.sysidIdx = sidIdx_q;
endmodule : pstel_manager
`default_nettype wire

// *** testbench/pstel_link_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module pstel_link_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Manager to converter
  input wire logic syncLine,
  input wire logic [pstel_pkg::COEF_W-1:0] propCoeff,
  input wire logic [pstel_pkg::COEF_W-1:0] integCoeff,
  input wire logic [pstel_pkg::COEF_W-1:0] derivCoeff,
  input wire logic [pstel_pkg::COEF_W-1:0] rolloffCoeff,
  input wire logic [pstel_pkg::DROOP_W-1:0] droopSetting,
  input wire logic sysidEn,
  // Converter to manager
  input wire logic sysidDone,
  input wire logic [pstel_pkg::ADC_W-1:0] voltReading,
  input wire logic [pstel_pkg::TEL_W-1:0] curReading,
  input wire logic [pstel_pkg::TEL_W-1:0] tempReading,
  input wire logic csOut,
  input wire logic csOe
);
  import pstel_pkg::*;
  logic [5:0] sinceFall_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Cycles since the sync line fell; saturates so a stray update stays visible
  always_ff @(posedge core_clk)
  begin
    if (reset)
      sinceFall_q <= 6'h3f;
    else if ($fell(syncLine))
      sinceFall_q <= 6'h00;
    else if (sinceFall_q != 6'h3f)
      sinceFall_q <= sinceFall_q + 6'h01;
  end
  // Sync line shape and what may move with it
  property p_lowHalf;
    $fell(syncLine) |-> ##25 $rose(syncLine);
  endproperty
  a_lowHalf: assert property (p_lowHalf) else $error("sync low phase wrong");
  property p_highHold;
    $rose(syncLine) |=> syncLine [*8];
  endproperty
  a_highHold: assert property (p_highHold) else $error("sync high phase short");
  property p_coefAtFall;
    ($changed(propCoeff) || $changed(integCoeff) || $changed(derivCoeff)
      || $changed(rolloffCoeff)) |-> $fell(syncLine);
  endproperty
  a_coefAtFall: assert property (p_coefAtFall) else $error("coefficient moved off fall");
  property p_droopHold;
    !$fell(syncLine) |-> $stable(droopSetting);
  endproperty
  a_droopHold: assert property (p_droopHold) else $error("droop moved off fall");
  property p_doneNeedsEn;
    $rose(sysidDone) |-> sysidEn;
  endproperty
  a_doneNeedsEn: assert property (p_doneNeedsEn) else $error("done without run");
  property p_doneDrops;
    $fell(sysidEn) |-> ##[0:4] !sysidDone;
  endproperty
  a_doneDrops: assert property (p_doneDrops) else $error("done stuck after stop");
  property p_csPolarity;
    $rose(csOe) |-> !csOut && sinceFall_q inside {[2:3]};
  endproperty
  a_csPolarity: assert property (p_csPolarity) else $error("share line driven high");
  property p_telTime;
    ($changed(voltReading) || $changed(curReading) || $changed(tempReading))
      |-> sinceFall_q inside {[2:8]};
  endproperty
  a_telTime: assert property (p_telTime) else $error("telemetry off period start");
  // Main scenarios reached
  c_done: cover property ($rose(sysidDone));
  c_share: cover property ($rose(csOe));
  c_droop: cover property ($changed(droopSetting));
endmodule : pstel_link_assertions
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pstel_pkg::*;
  localparam int REFRESH = 200;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [AV_AW-1:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [ADC_W-1:0] refVoltage = 12'h800;
  logic [ADC_W-1:0] adcVoltage = 12'h5a5;
  logic [ADC_W-1:0] adcCurrent = 12'h800;
  logic [ADC_W-1:0] adcTemp = 12'h400;
  logic [ADC_W-1:0] pwmDuty;
  logic pwmStart;
  logic [31:0] rd;
  int n_errors = 0;
  int tests_run = 0;
  int waits = 0;
  // Both ends face each other across one link
  pstel_link_if link();
  pstel_manager #(.REFRESH_CYC(REFRESH)) u_pstel_manager (.core_clk, .reset, .address, .read,
    .write, .writedata, .readdata, .waitrequest, .link(link));
  pstel_converter u_pstel_converter (.core_clk, .reset, .link(link), .refVoltage, .adcVoltage,
    .adcCurrent, .adcTemp, .pwmDuty, .pwmStart);
  pstel_link_assertions u_pstel_link_assertions (.core_clk, .reset, .syncLine(link.syncLine),
    .propCoeff(link.propCoeff), .integCoeff(link.integCoeff), .derivCoeff(link.derivCoeff),
    .rolloffCoeff(link.rolloffCoeff), .droopSetting(link.droopSetting), .sysidEn(link.sysidEn),
    .sysidDone(link.sysidDone), .voltReading(link.voltReading), .curReading(link.curReading),
    .tempReading(link.tempReading), .csOut(link.csOut), .csOe(link.csOe));
  // Clock
  always #20 core_clk = ~core_clk;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic fail;
    n_errors++;
    $display("timeout at %0t", $time);
    end_of_test();
  endtask : fail
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : check
  // One bus cycle; request held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [AV_AW-1:0] a, input logic [31:0] d);
    int i;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    i = 0;
    do
    begin
      @(posedge core_clk);
      i++;
    end
    while (waitrequest !== 1'b0 && i < 50);
    if (i >= 50)
      fail();
    waits = i;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask : xfer
  task automatic waitFall;
    logic last;
    int i;
    last = 1'b0;
    for (i = 0; i < 60; i++)
    begin
      @(posedge core_clk);
      if (last === 1'b1 && link.syncLine === 1'b0)
        break;
      last = link.syncLine;
    end
    if (i >= 60)
      fail();
  endtask : waitFall
  // Counts over exactly one sync period
  task automatic countPer(output int nOe, output int nStart);
    nOe = 0;
    nStart = 0;
    repeat (50)
    begin
      @(posedge core_clk);
      nOe += int'(link.csOe === 1'b1);
      nStart += int'(pwmStart === 1'b1);
    end
  endtask : countPer
  task automatic tReset;
    check(32'(link.propCoeff), 32'h0);
    xfer(1'b0, OFF_PROP, 32'h0);
    check(rd, 32'h0);
    xfer(1'b0, OFF_TMO, 32'h0);
    check(rd, 32'h96);
    xfer(1'b1, 6'h3c, 32'hff);
    xfer(1'b0, 6'h3c, 32'h0);
    check(rd, 32'h0);
    $display("reset test done");
  endtask : tReset
  // Start without a coefficient set is ignored
  task automatic tRefuse;
    xfer(1'b1, OFF_CTRL, 32'h1);
    waitFall();
    waitFall();
    check(32'(link.sysidEn), 32'h0);
    xfer(1'b0, OFF_STAT, 32'h0);
    check(rd, 32'h0);
    $display("refuse test done");
  endtask : tRefuse
  task automatic tCoeffs;
    xfer(1'b1, OFF_PROP, 32'h13);
    xfer(1'b1, OFF_INTEG, 32'h25);
    xfer(1'b1, OFF_DERIV, 32'h37);
    xfer(1'b1, OFF_ROLL, 32'h49);
    xfer(1'b0, OFF_ROLL, 32'h0);
    check(rd, 32'h49);
    xfer(1'b0, OFF_STAT, 32'h0);
    check(rd, 32'h0f);
    waitFall();
    waitFall();
    check({link.propCoeff, link.integCoeff, link.derivCoeff, link.rolloffCoeff},
      32'h13253749);
    $display("coefficient test done");
  endtask : tCoeffs
  // Follower gets two steps more, saturating
  task automatic tDroop;
    logic [7:0] ctl [4] = '{8'h30, 8'h32, 8'he2, 8'hf0};
    logic [3:0] want [4] = '{4'h3, 4'h5, 4'hf, 4'hf};
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'b1, OFF_CTRL, 32'(ctl[k]));
      waitFall();
      waitFall();
      check(32'(link.droopSetting), 32'(want[k]));
    end
    xfer(1'b1, OFF_CTRL, 32'h0);
    $display("droop test done");
  endtask : tDroop
  // Current reading corrected by temperature, then refreshed to the host
  task automatic tTelem;
    waitFall();
    waitFall();
    check({link.voltReading, link.tempReading, link.curReading}, 32'h5a54080);
    adcTemp <= 12'h800;
    waitFall();
    waitFall();
    check({link.tempReading, link.curReading}, 32'h8060);
    repeat (REFRESH + 60) @(posedge core_clk);
    xfer(1'b0, OFF_TELV, 32'h0);
    check(rd, 32'h5a5);
    xfer(1'b0, OFF_TELIT, 32'h0);
    check(rd, 32'h8060);
    $display("telemetry test done");
  endtask : tTelem
  // Low time of own share pulse against current and droop
  task automatic tShare;
    logic [11:0] cur [4] = '{12'h800, 12'hc00, 12'h000, 12'h800};
    logic [7:0] ctl [4] = '{8'h00, 8'h00, 8'h00, 8'h30};
    int want [4] = '{25, 37, 0, 22};
    int nOe;
    int nStart;
    adcTemp <= 12'h400;
    for (int k = 0; k < 4; k++)
    begin
      adcCurrent <= cur[k];
      xfer(1'b1, OFF_CTRL, 32'(ctl[k]));
      repeat (3) waitFall();
      countPer(nOe, nStart);
      check(32'(nOe), 32'(want[k]));
    end
    xfer(1'b1, OFF_CTRL, 32'h0);
    adcCurrent <= 12'h800;
    $display("share test done");
  endtask : tShare
  // One switching start per sync period, shortly after the fall
  task automatic tSync;
    int n;
    int nOe;
    waitFall();
    for (n = 0; n < 10 && pwmStart !== 1'b1; n++)
      @(posedge core_clk);
    check(32'(n >= 1 && n <= 8), 32'h1);
    countPer(nOe, n);
    check(32'(n), 32'h1);
    check(32'(pwmDuty), 32'hfff);
    waitFall();
    xfer(1'b0, OFF_TMO, 32'h0);
    check(32'(waits), 32'h5);
    $display("sync test done");
  endtask : tSync
  task automatic tSysid;
    int i;
    xfer(1'b1, OFF_CTRL, 32'h1);
    xfer(1'b0, OFF_STAT, 32'h0);
    check(rd, 32'h1f);
    for (i = 0; i < 1000 && rd[5] !== 1'b1; i++)
      xfer(1'b0, OFF_STAT, 32'h0);
    if (i >= 1000)
      fail();
    check(rd, 32'h2f);
    xfer(1'b1, OFF_SIDIDX, 32'hf);
    repeat (2) @(posedge core_clk);
    xfer(1'b0, OFF_SIDDAT, 32'h0);
    check(rd, 32'h5a5);
    waitFall();
    check(32'(link.sysidEn), 32'h0);
    $display("identification test done");
  endtask : tSysid
  // Main sequence
  initial
  begin
    link.csExt <= 1'b1;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    tReset();
    tRefuse();
    tCoeffs();
    tDroop();
    tTelem();
    tShare();
    tSync();
    tSysid();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
